// *** jbs_test_data_regs.sv ***
// ID register, boundary-scan chain and pin multiplexing of the test port
`timescale 1ns/10ps
module jbs_test_data_regs #(
    parameter logic [3:0]  ID_VERSION = 4'h2,    // Arbitrary value
    parameter logic [15:0] ID_PART    = 16'h1234, // Arbitrary value
    parameter logic [10:0] ID_MAKER   = 11'h2a5   // Arbitrary value
) (
    // System clock and reset
    input  wire logic              clk_sys_i,
    input  wire logic              rst_i,
    // Test clock side, driven by the access-port controller
    input  wire logic              tck_i,
    input  wire logic [4:0]        ir_i,
    input  wire jbs_pkg::jbs_tap_s tap_i,
    input  wire logic              tdi_i,
    output logic                   tdo_o,
    // Core side of the pins
    input  wire jbs_pkg::jbs_drive_s core_drv_i,
    output jbs_pkg::jbs_sense_s      core_sns_o,
    // Pad side of the pins
    input  wire jbs_pkg::jbs_sense_s pad_sns_i,
    output jbs_pkg::jbs_drive_s      pad_drv_o
);
    import jbs_pkg::*;

    localparam logic [31:0] ID_VALUE = {ID_VERSION, ID_PART, ID_MAKER, 1'b1};

    // Test clock domain state
    typedef struct packed {
        logic [31:0]       id_sh;
        logic [N_CELL-1:0] bsr;
        logic [N_CELL-1:0] upd;
        logic              byp;
        jbs_pin_mode_e     mode;
        logic              tgl;
        jbs_sense_s        pad1;
        jbs_sense_s        pad2;
        jbs_drive_s        core1;
        jbs_drive_s        core2;
    } jbs_tck_s;

    // System clock domain state
    typedef struct packed {
        logic              tgl1;
        logic              tgl2;
        logic              tgl3;
        jbs_pin_mode_e     mode;
        logic [N_CELL-1:0] upd;
        jbs_sense_s        pad1;
        jbs_sense_s        pad2;
        jbs_drive_s        drv;
    } jbs_sys_s;

    jbs_tck_s          t_r;
    jbs_tck_s          t_nxt;
    jbs_sys_s          s_r;
    jbs_sys_s          s_nxt;
    jbs_sel_e          dsel;
    jbs_pin_mode_e     mode_dec;
    logic [N_CELL-1:0] obs;
    // Two spare positions stand for control cell 45, which lies past the covered chain
    logic [N_CELL+1:0] obs_wide;
    logic [N_CELL+1:0] upd_wide;

    // Instruction decode
    always_comb begin
        unique case (ir_i)
            IR_EXTEST: begin
                dsel     = SEL_BSR;   // [R13]
                mode_dec = PM_DRIVE;
            end
            IR_SAMPLE: begin
                dsel     = SEL_BSR;   // [R12]
                mode_dec = PM_NORMAL;
            end
            IR_IDCODE: begin
                dsel     = SEL_ID;    // [R11]
                mode_dec = PM_NORMAL;
            end
            IR_CLAMP: begin
                dsel     = SEL_BYP;
                mode_dec = PM_DRIVE;
            end
            IR_HIGHZ: begin
                dsel     = SEL_BYP;
                mode_dec = PM_HIGHZ;
            end
            default: begin
                dsel     = SEL_BYP;   // [R14]
                mode_dec = PM_NORMAL;
            end
        endcase
    end

    // Parallel view of the pins seen by each cell; internal cells read zero
    always_comb begin
        obs_wide = '0;
        for (int i = 0; i < N_OUT; i++) begin
            obs_wide[i] = t_r.core2.downstream_reset_out[i];     // [R09]
        end
        for (int i = 0; i < N_IN; i++) begin
            obs_wide[IN_POS+i] = t_r.pad2.in[i];                 // [R09]
        end
        for (int k = 0; k < N_BID; k++) begin
            obs_wide[BID_POS[k]] = t_r.pad2.io_in[k];            // [R08] [R10]
            obs_wide[BID_CTL[k]] = obs_wide[BID_CTL[k]] | t_r.core2.io_oe[k];
        end
        obs = obs_wide[N_CELL-1:0];
    end

    // Test clock domain next state
    always_comb begin
        t_nxt       = t_r;
        t_nxt.pad1  = pad_sns_i;
        t_nxt.pad2  = t_r.pad1;
        t_nxt.core1 = core_drv_i;
        t_nxt.core2 = t_r.core1;
        t_nxt.mode  = mode_dec;
        if (mode_dec != t_r.mode) begin
            t_nxt.tgl = ~t_r.tgl;
        end
        if (tap_i.capture) begin
            unique case (dsel)
                SEL_BSR: t_nxt.bsr = obs;                        // [R07] [R05]
                SEL_ID:  t_nxt.id_sh = ID_VALUE;                 // [R01] [R02] [R15]
                SEL_BYP: t_nxt.byp = 1'b0;
            endcase
        end else if (tap_i.shift) begin
            unique case (dsel)
                SEL_BSR: t_nxt.bsr = {tdi_i, t_r.bsr[N_CELL-1:1]};   // [R03]
                SEL_ID:  t_nxt.id_sh = {tdi_i, t_r.id_sh[31:1]};     // [R15]
                SEL_BYP: t_nxt.byp = tdi_i;                          // [R14]
            endcase
        end else if (tap_i.update && dsel == SEL_BSR) begin
            t_nxt.upd = t_r.bsr;                                 // [R12] [R13]
            t_nxt.tgl = ~t_r.tgl;
        end
        if (tap_i.reset) begin
            t_nxt.id_sh = ID_VALUE;
            t_nxt.bsr   = BSR_RST;
            t_nxt.upd   = BSR_RST;
            t_nxt.byp   = 1'b0;
            t_nxt.mode  = PM_NORMAL;
            t_nxt.tgl   = 1'b0;
        end
    end

    always_ff @(posedge tck_i) begin
        t_r <= t_nxt;
    end

    // Serial output of the selected register
    always_comb begin
        tdo_o = 1'b0;
        unique case (dsel)
            SEL_BSR: tdo_o = t_r.bsr[0];                         // [R03]
            SEL_ID:  tdo_o = t_r.id_sh[0];                       // [R15]
            SEL_BYP: tdo_o = t_r.byp;                            // [R14]
        endcase
    end

    // Control cell 45 is held outside this chain, so its pins stay undriven here
    assign upd_wide = {2'b00, s_r.upd};

    // System domain: takes mode and update word when the toggle moves
    always_comb begin
        s_nxt      = s_r;
        s_nxt.tgl1 = t_r.tgl;
        s_nxt.tgl2 = s_r.tgl1;
        s_nxt.tgl3 = s_r.tgl2;
        s_nxt.pad1 = pad_sns_i;
        s_nxt.pad2 = s_r.pad1;
        if (s_r.tgl3 != s_r.tgl2) begin
            s_nxt.mode = t_r.mode;
            s_nxt.upd  = t_r.upd;
        end
        unique case (s_r.mode)
            PM_NORMAL: s_nxt.drv = core_drv_i;                   // [R06]
            PM_DRIVE: begin
                for (int i = 0; i < N_OUT; i++) begin
                    s_nxt.drv.downstream_reset_out[i] = s_r.upd[i];
                end
                for (int k = 0; k < N_BID; k++) begin
                    s_nxt.drv.io_out[k] = s_r.upd[BID_POS[k]];
                    s_nxt.drv.io_oe[k]  = upd_wide[BID_CTL[k]];  // [R16]
                end
            end
            PM_HIGHZ: begin
                s_nxt.drv.downstream_reset_out = core_drv_i.downstream_reset_out;
                s_nxt.drv.io_out = core_drv_i.io_out;
                s_nxt.drv.io_oe  = '0;
            end
            default: s_nxt.drv = core_drv_i;
        endcase
        if (rst_i) begin
            s_nxt = '0;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        s_r <= s_nxt;
    end

    // Pin-side outputs; power, ground and test-port pins never pass here [R04]
    assign pad_drv_o  = s_r.drv;
    assign core_sns_o = s_r.pad2;

    // Checks in the test clock domain
    sequence id_capture_s;
        tap_i.capture && dsel == SEL_ID;
    endsequence

    sequence id_shift_s;
        tap_i.shift && !tap_i.capture && dsel == SEL_ID;
    endsequence

    chk_id_capture_value: assert property ( // [R01]
        @(posedge tck_i) disable iff (tap_i.reset)
        id_capture_s |=> t_r.id_sh == ID_VALUE && t_r.id_sh[31:28] == ID_VERSION)
        else $error("ID capture value wrong");

    chk_id_lsb_one: assert property ( // [R02]
        @(posedge tck_i) disable iff (tap_i.reset)
        id_capture_s ##1 !tap_i.reset |-> tdo_o == 1'b1)
        else $error("ID bit 0 not one");

    chk_id_shift_order: assert property ( // [R15]
        @(posedge tck_i) disable iff (tap_i.reset)
        id_capture_s ##1 id_shift_s ##1 (dsel == SEL_ID) |->
            t_r.id_sh[30:0] == ID_VALUE[31:1] && t_r.id_sh[31] == $past(tdi_i))
        else $error("ID shift order wrong");

    chk_bsr_shift_in: assert property ( // [R03]
        @(posedge tck_i) disable iff (tap_i.reset)
        (tap_i.shift && !tap_i.capture && dsel == SEL_BSR) |=>
            t_r.bsr[N_CELL-1] == $past(tdi_i) && t_r.bsr[N_CELL-2:0] == $past(t_r.bsr[N_CELL-1:1]))
        else $error("Chain shift wrong");

    chk_capture_pins: assert property ( // [R07]
        @(posedge tck_i) disable iff (tap_i.reset)
        (tap_i.capture && dsel == SEL_BSR) |=>
            t_r.bsr[4] == $past(t_r.pad2.in[1]) && t_r.bsr[38] == 1'b0 &&
            t_r.bsr[19] == $past(t_r.pad2.io_in[12]))
        else $error("Parallel capture wrong");

    chk_undef_bypass: assert property ( // [R14]
        @(posedge tck_i) disable iff (tap_i.reset)
        (ir_i == 5'h1f && tap_i.shift && !tap_i.capture) ##1 (ir_i == 5'h1f) |->
            tdo_o == $past(tdi_i))
        else $error("Bypass path wrong");

    chk_update_hold: assert property ( // [R12]
        @(posedge tck_i) disable iff (tap_i.reset)
        !(tap_i.update && dsel == SEL_BSR) |=> t_r.upd == $past(t_r.upd))
        else $error("Update stage moved without update");

    sequence bsr_capture_s;
        tap_i.capture && dsel == SEL_BSR;
    endsequence

    chk_control_capture: assert property ( // [R09]
        @(posedge tck_i) disable iff (tap_i.reset)
        bsr_capture_s |=>
            t_r.bsr[12] == $past(|t_r.core2.io_oe[11:0]) &&
            t_r.bsr[20] == $past(t_r.core2.io_oe[12]))
        else $error("Control cell capture wrong");

    chk_reset_cells: assert property ( // [R09]
        @(posedge tck_i) disable iff (tap_i.reset)
        bsr_capture_s |=> t_r.bsr[2:0] == $past(t_r.core2.downstream_reset_out))
        else $error("Reset output cell capture wrong");

    chk_sample_mode: assert property ( // [R12]
        @(posedge tck_i) disable iff (tap_i.reset)
        (ir_i == IR_SAMPLE) |=> t_r.mode == PM_NORMAL)
        else $error("Sample takes the pins");

    chk_extest_mode: assert property ( // [R13]
        @(posedge tck_i) disable iff (tap_i.reset)
        (ir_i == IR_EXTEST) |=> t_r.mode == PM_DRIVE)
        else $error("Extest leaves the pins");

    // Checks in the system clock domain
    chk_normal_pass: assert property ( // [R06]
        @(posedge clk_sys_i) disable iff (rst_i)
        (s_r.mode == PM_NORMAL) |=> pad_drv_o == $past(core_drv_i))
        else $error("Pins altered in normal mode");

    chk_oe_gate: assert property ( // [R16]
        @(posedge clk_sys_i) disable iff (rst_i)
        (s_r.mode == PM_DRIVE) |=>
            pad_drv_o.io_oe[0] == $past(s_r.upd[12]) &&
            pad_drv_o.io_oe[12] == $past(s_r.upd[20]) &&
            pad_drv_o.io_oe[24] == 1'b0 &&
            pad_drv_o.io_out[12] == $past(s_r.upd[19]))
        else $error("Output enable not from control cell");

    chk_hiz_float: assert property ( // [R16]
        @(posedge clk_sys_i) disable iff (rst_i)
        (s_r.mode == PM_HIGHZ) |=> pad_drv_o.io_oe == '0)
        else $error("Pins driven in high-impedance mode");

    chk_drive_resets: assert property ( // [R13]
        @(posedge clk_sys_i) disable iff (rst_i)
        (s_r.mode == PM_DRIVE) |=> pad_drv_o.downstream_reset_out == $past(s_r.upd[2:0]))
        else $error("Reset outputs not from update stage");

    chk_sense_sync: assert property ( // [R06]
        @(posedge clk_sys_i) disable iff (rst_i)
        1'b1 |-> ##2 core_sns_o == $past(pad_sns_i, 2))
        else $error("Pin sense not passed to core");
endmodule

// *** jbs_pkg.sv ***
// Constants, types and carriers for the boundary-scan test data registers
//
// Function
// [R01] The 32-bit read-only ID word holds version 31:28, part number 27:12, maker code 11:1.
// [R02] ID bit 0 always reads as one.
// [R03] The boundary chain shifts from the test data input toward the test data output.
// [R04] Power, ground and test-port pins have no cells in the chain.
// [R05] Every cell is one of four kinds chosen by the function of its pin.
// [R06] Cells are test-only logic and leave the pins alone outside the driving instructions.
// [R07] Under SAMPLE and EXTEST the cells load in parallel from pins and drivers on a rising TCK.
// [R08] The chain has one cell per covered pin function plus control cells.
// [R09] Cells 0-2 are reset outputs, 3-5 inputs, 6-11 and 13-18 bidirectional sharing control 12.
// [R10] GPIO cells 19,21..33 each have their own control; 35-37,39,41 use control 45. Here no cell 45 exists, so those pins never drive under EXTEST or CLAMP.
// [R11] Code 01100 selects the ID register.
// [R12] Code 00001 selects the chain to sample and preload without taking the pins.
// [R13] Code 00000 selects the chain and drives the pins from it.
// [R14] Every undefined code acts as bypass with a one-bit path.
// [R15] A selected ID register captures its value and shifts out least significant bit first.
// [R16] Under EXTEST a bidirectional pin drives only when its control cell enables it.
package jbs_pkg;
    localparam int unsigned N_CELL = 44;
    localparam int unsigned N_OUT  = 3;
    localparam int unsigned N_IN   = 3;
    localparam int unsigned N_BID  = 25;
    localparam int unsigned IN_POS = 3;
    localparam int unsigned ID_VER_LSB  = 28;
    localparam int unsigned ID_PART_LSB = 12;
    localparam int unsigned ID_MFR_LSB  = 1;
    localparam logic [4:0] IR_EXTEST = 5'h00;
    localparam logic [4:0] IR_SAMPLE = 5'h01;
    localparam logic [4:0] IR_CLAMP  = 5'h04;
    localparam logic [4:0] IR_HIGHZ  = 5'h05;
    localparam logic [4:0] IR_IDCODE = 5'h0c;
    localparam logic [N_CELL-1:0] BSR_RST = '0;
    // Chain position of each bidirectional pin and of its control cell
    localparam int unsigned BID_POS [N_BID] = '{6, 7, 8, 9, 10, 11, 13, 14, 15, 16, 17, 18,
        19, 21, 23, 25, 27, 29, 31, 33, 35, 36, 37, 39, 41};
    localparam int unsigned BID_CTL [N_BID] = '{12, 12, 12, 12, 12, 12, 12, 12, 12, 12, 12, 12,
        20, 22, 24, 26, 28, 30, 32, 34, 45, 45, 45, 45, 45};

    typedef enum logic [1:0] {SEL_BYP, SEL_BSR, SEL_ID} jbs_sel_e;
    typedef enum logic [1:0] {PM_NORMAL, PM_DRIVE, PM_HIGHZ} jbs_pin_mode_e;

    typedef struct packed {
        logic capture;
        logic shift;
        logic update;
        logic reset;
    } jbs_tap_s;

    typedef struct packed {
        logic [N_OUT-1:0] downstream_reset_out;
        logic [N_BID-1:0] io_out;
        logic [N_BID-1:0] io_oe;
    } jbs_drive_s;

    typedef struct packed {
        logic [N_IN-1:0]  in;
        logic [N_BID-1:0] io_in;
    } jbs_sense_s;
endpackage

// *** jbs_tester.sv ***
// Board tester model that drives the test access port
`timescale 1ns/10ps
module jbs_tester (
    // Test port toward the device
    output logic              tck_o,
    output logic [4:0]        ir_o,
    output jbs_pkg::jbs_tap_s tap_o,
    output logic              tdi_o,
    input  wire logic         tdo_i
);
    import jbs_pkg::*;
    initial begin
        tck_o = 1'b0;
        ir_o  = 5'h1f;
        tap_o = '0;
        tdi_o = 1'b0;
    end
    // Test clock runs only inside frames; inputs change while it is low
    // Uneven phases keep its rising edge clear of the system clock edges
    task automatic pulse();
        #61.3 tck_o = 1'b1;
        #63.7 tck_o = 1'b0;
    endtask
    task automatic tap_reset();
        jbs_tap_s st;
        st = '0;
        st.reset = 1'b1;
        tap_o = st;
        pulse();
        tap_o = '0;
    endtask
    // Capture, n shifts sampling the output before each edge, optional update
    task automatic scan(input logic [4:0] code, input int n, input logic [63:0] din,
                        input bit upd, output logic [63:0] dout);
        jbs_tap_s st;
        dout = '0;
        ir_o = code;
        st = '0;
        st.capture = 1'b1;
        tap_o = st;
        pulse();
        st = '0;
        st.shift = 1'b1;
        tap_o = st;
        for (int i = 0; i < n; i++) begin
            dout[i] = tdo_i;
            tdi_o = din[i];
            pulse();
        end
        // Released data line shows the inverse of its last value
        tdi_o = ~tdi_o;
        st = '0;
        st.update = upd;
        tap_o = st;
        pulse();
        tap_o = '0;
    endtask
endmodule

// *** tb_jbs_test_data_regs.sv ***
// Self-checking bench for the ID register and boundary-scan chain
`timescale 1ns/10ps
module tb_jbs_test_data_regs;
    import jbs_pkg::*;
    logic        clk_sys_i = 1'b0;
    logic        rst_i     = 1'b1;
    logic        tck;
    logic        tdi;
    logic        tdo;
    logic [4:0]  ir;
    jbs_tap_s    tap;
    jbs_drive_s  core_drv  = '0;
    jbs_drive_s  pad_drv;
    jbs_sense_s  pad_sns   = '0;
    jbs_sense_s  core_sns;
    logic [63:0] d;
    logic [63:0] p;
    int          err_total  = 0;
    int          num_checks = 0;

    always #2.5 clk_sys_i = ~clk_sys_i;

    jbs_test_data_regs #(.ID_VERSION(4'h3), .ID_PART(16'habcd), .ID_MAKER(11'h155))
        jbs_test_data_regs_inst (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .tck_i(tck),
        .ir_i(ir), .tap_i(tap), .tdi_i(tdi), .tdo_o(tdo), .core_drv_i(core_drv),
        .core_sns_o(core_sns), .pad_sns_i(pad_sns), .pad_drv_o(pad_drv));
    jbs_tester jbs_tester_inst (.tck_o(tck), .ir_o(ir), .tap_o(tap), .tdi_o(tdi), .tdo_i(tdo));

    task automatic chk(input string name, input logic [63:0] exp, input logic [63:0] got);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected %s: expected %h, seen %h", name, exp, got);
        end
    endtask
    task automatic settle();
        repeat (12) @(negedge clk_sys_i);
    endtask
    task automatic conclude();
        $display("checks %0d, mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    initial begin
        logic [4:0] codes [6];
        codes = '{5'h04, 5'h05, 5'h02, 5'h09, 5'h0a, 5'h1f};
        repeat (20) @(posedge clk_sys_i);
        @(negedge clk_sys_i);
        rst_i = 1'b0;
        jbs_tester_inst.tap_reset();
        // Pins follow the core outside test instructions
        @(negedge clk_sys_i);
        core_drv.downstream_reset_out = 3'b010;
        core_drv.io_out = 25'h0aa55aa;
        core_drv.io_oe = 25'h1f00fff;
        pad_sns.in = 3'b110;
        pad_sns.io_in = 25'h1555555;
        settle();
        chk("pad drive", 64'(core_drv), 64'(pad_drv));
        chk("core sense", 64'(pad_sns), 64'(core_sns));
        $display("test normal pins done");
        // Identification word, least significant bit first
        jbs_tester_inst.scan(IR_IDCODE, 32, 64'h0, 1'b0, d);
        chk("id word", {32'h0, 4'h3, 16'habcd, 11'h155, 1'b1}, d);
        chk("id bit0", 64'h1, 64'(d[0]));
        $display("test id done");
        // Sample captures pins, chain is 44 cells long, pins untouched
        jbs_tester_inst.scan(IR_SAMPLE, 46, 64'h2, 1'b0, d);
        chk("reset out cells", 64'h2, 64'(d[2:0]));
        chk("input cells", 64'h6, 64'(d[5:3]));
        chk("control 12", 64'h1, 64'(d[12]));
        chk("control 20", 64'h0, 64'(d[20]));
        chk("internal cells", 64'h0, 64'(d[43:42]));
        chk("chain length", 64'h2, 64'(d[45:44]));
        chk("pins under sample", 64'(core_drv), 64'(pad_drv));
        $display("test sample done");
        // Extest drives the pins from the update stage
        p = '0;
        p[2:0] = 3'b101;
        p[11:6] = 6'b110010;
        p[12] = 1'b1;
        p[18:13] = 6'b011011;
        p[19] = 1'b1;
        jbs_tester_inst.scan(IR_EXTEST, 44, p, 1'b1, d);
        settle();
        chk("reset out pins", 64'h5, 64'(pad_drv.downstream_reset_out));
        chk("bidir data", 64'({p[18:13], p[11:6]}), 64'(pad_drv.io_out[11:0]));
        chk("bidir enable", 64'hfff, 64'(pad_drv.io_oe[11:0]));
        chk("gpio0 float", 64'h0, 64'(pad_drv.io_oe[12]));
        chk("gpio0 data", 64'h1, 64'(pad_drv.io_out[12]));
        chk("control 45 pins", 64'h0, 64'(pad_drv.io_oe[24:20]));
        chk("extest capture", 64'h2, 64'(d[2:0]));
        $display("test extest done");
        // Other codes give a one-bit path capturing zero
        foreach (codes[i]) begin
            jbs_tester_inst.scan(codes[i], 2, 64'h3, 1'b0, d);
            chk("bypass path", 64'h2, d);
            if (codes[i] == IR_HIGHZ) begin
                chk("highz enables", 64'h0, 64'(pad_drv.io_oe));
            end
            if (codes[i] == IR_CLAMP) begin
                chk("clamp outputs", 64'h5, 64'(pad_drv.downstream_reset_out));
            end
        end
        settle();
        chk("pins after bypass", 64'(core_drv), 64'(pad_drv));
        $display("test bypass done");
        conclude();
    end

    initial begin
        #300000;
        err_total++;
        $display("unexpected watchdog: expected end of tests, seen timeout");
        conclude();
    end
endmodule
